// [rtl/rtcl_pkg.sv]
// shared constants, field layout and state codes of the command legality block
package rtcl_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 40;
	localparam int LEGAL_SETTLE_US   = 3;
	localparam int LEGAL_WAIT_CYC    = (LEGAL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BACKEND_LIMIT_US  = 10;
	localparam int BACKEND_LIMIT_CYC = (BACKEND_LIMIT_US * 1000) / CLK_PERIOD_NS;
	localparam int CLR_MIN_HIGH      = 3;
	localparam int TX_WORD_LIMIT     = 32;

	// ----------------------------------------
	// command and vector fields
	// ----------------------------------------
	localparam int CMD_BCAST_BIT = 11;
	localparam int CMD_TX_BIT    = 10;
	localparam int CMD_SA_MSB    = 9;
	localparam int CMD_SA_LSB    = 5;
	localparam int CMD_WC_MSB    = 4;
	localparam int CMD_WC_LSB    = 0;
	localparam int VEC_GOOD_BIT  = 6;
	localparam int VEC_TX_BIT    = 5;
	localparam logic [4:0] SA_MODE_LO = 5'h00;
	localparam logic [4:0] SA_MODE_HI = 5'h1f;
	localparam logic [4:0] MC_LAST_LO = 5'h08;
	localparam logic [4:0] MC_HI_FIRST = 5'h10;
	localparam logic [4:0] MC_HI_LAST = 5'h15;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CMD    = 8'h08;
	localparam logic [7:0] ADDR_VECT   = 8'h0c;
	localparam logic [7:0] ADDR_BITW   = 8'h10;
	localparam logic [7:0] ADDR_LASTSW = 8'h14;
	localparam int CTRL_LEGAL_SEL_BIT  = 0;
	localparam logic CTRL_RESET        = 1'b0;
	localparam logic [15:0] BIT_TIMEOUT_MASK = 16'h0003;
	localparam logic [15:0] LAST_SW_INIT     = 16'h0000;
	localparam logic [31:0] RDATA_ZERO       = 32'h0000_0000;

	// ----------------------------------------
	// legality sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_CHECK  = 2'b01,
		ST_ACTIVE = 2'b10
	} rtcl_state_e;

	// mode codes this terminal supports, with their required direction
	function automatic logic rtcl_mode_legal(input logic tx, input logic [4:0] code);
		logic hi_tx;
		hi_tx = (code == 5'h10) || (code == 5'h12) || (code == 5'h13);
		if (code <= MC_LAST_LO)
			return tx;
		else if (code >= MC_HI_FIRST && code <= MC_HI_LAST)
			return hi_tx ? tx : !tx;
		else
			return 1'b0;
	endfunction

endpackage

// [rtl/rtcl_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module rtcl_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1_q;
	logic [W-1:0] stage2_q;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_q <= RST_VAL;
			stage2_q <= RST_VAL;
		end
		else
		begin
			stage1_q <= d;
			stage2_q <= stage1_q;
		end
	end

	assign q = stage2_q;
endmodule

// [rtl/rtcl_timer.sv]
// one-shot cycle timer with abort, expiry as a registered pulse
`timescale 1ns/1ps
module rtcl_timer #(
	parameter int CW    = 8,
	parameter int LIMIT = 4
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic start,
	input  wire logic abort,
	output logic      expired
);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
	logic          active_q;
	logic [CW-1:0] count_q;
	logic          expired_q;

	// abort wins over start; start reloads a running count
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			active_q  <= 1'b0;
			count_q   <= '0;
			expired_q <= 1'b0;
		end
		else
		begin
			expired_q <= active_q && !abort && !start && (count_q == LAST);
			if (abort)
				active_q <= 1'b0;
			else if (start)
			begin
				active_q <= 1'b1;
				count_q  <= '0;
			end
			else if (active_q)
			begin
				active_q <= (count_q != LAST);
				count_q  <= count_q + 1'b1;
			end
		end
	end

	assign expired = expired_q;
endmodule

// [rtl/rtcl_core.sv]
// command legality, interrupt vector and side-band control of a remote terminal
// Notes on behaviour
// - vector bit 5 marks transmit, bits 4:0 carry the subaddress
// - vector bit 6 is one for a good block, zero for bad
// - interrupt request rises on transfer or mode done, held until acknowledged
// - acknowledge high drives the interrupt request low
// - with acknowledge held high, each interrupt gives a one-cycle request pulse
// - failure flag sets when a backend access exceeds its allowed time
// - error clear held for three cycles clears failure and other error state
// - over-length test lets transmit run past 32 words, then shuts down, sets timeout
// - illegal state gives a single-cycle flag pulse
// - power-up reset sets the last status word when its parameter is one
// - external self-test word and enable used when its parameter is one
// - inputs sampled and outputs updated on the rising clock edge
// - select zero: internal logic accepts supported mode codes and all subaddresses
// - select one: legality comes only from the external accept input
// - active command: broadcast, transmit, subaddress, count or mode code
// - active command stays stable for the whole message
// - command strobe is a single-cycle pulse for a new command
// - internal validation result is presented on its own output
// - address latch enable marks when to capture the command for mapping
// - vector latch enable marks when to capture the command for the vector
`timescale 1ns/1ps
module rtcl_core #(
	parameter bit overlength_test_param   = 1'b0,
	parameter bit init_last_status_param  = 1'b0,
	parameter bit external_selftest_param = 1'b0
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        powerup_status_reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        rx_cmd_strobe,
	input  wire logic [11:0] rx_cmd_word,
	input  wire logic        msg_end,
	input  wire logic        xfer_done,
	input  wire logic        xfer_good,
	input  wire logic        mode_done,
	input  wire logic        backend_req,
	input  wire logic        tx_word_strobe,
	input  wire logic        status_word_load,
	input  wire logic [15:0] status_word_in,
	input  wire logic        other_fsm_illegal,
	input  wire logic        interrupt_acknowledge,
	input  wire logic        backend_grant_n,
	input  wire logic        backend_wait_n,
	input  wire logic        error_clear_input,
	input  wire logic        overlength_transmit_test,
	input  wire logic        external_selftest_word_enable,
	input  wire logic [15:0] external_selftest_word,
	input  wire logic        external_command_accept,
	output logic             interrupt_request_out,
	output logic      [6:0]  interrupt_reason_vector,
	output logic             backend_access_failure,
	output logic             illegal_state_flag,
	output logic      [11:0] active_command_bus,
	output logic             command_valid_strobe,
	output logic             internal_command_accept_out,
	output logic             address_map_latch_enable,
	output logic             vector_extend_latch_enable,
	output logic             command_decision,
	output logic             command_accepted,
	output logic             overlength_enable,
	output logic             tx_shutdown,
	output logic      [15:0] selftest_word,
	output logic      [15:0] last_status_word
);
	localparam int LEG_CW = $clog2(rtcl_pkg::LEGAL_WAIT_CYC + 1);
	localparam int WD_CW  = $clog2(rtcl_pkg::BACKEND_LIMIT_CYC + 1);
	localparam int SYNC_W = 23;
	localparam logic [SYNC_W-1:0] SYNC_RST = {2'b11, 21'h00_0000};
	localparam logic [1:0] CLR_LAST = 2'(rtcl_pkg::CLR_MIN_HIGH - 1);
	localparam logic [5:0] TX_LIMIT = 6'(rtcl_pkg::TX_WORD_LIMIT);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] pins_s;
	logic ack_s, clr_s, ovl_s, bit_en_s, ext_ok_s, grant_n_s, wait_n_s;
	logic [15:0] bit_word_s;

	// every pin passes two flops before use
	rtcl_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({backend_grant_n, backend_wait_n, interrupt_acknowledge, error_clear_input,
		            overlength_transmit_test, external_selftest_word_enable, external_command_accept,
		            external_selftest_word}),
		.q        (pins_s)
	);
	assign {grant_n_s, wait_n_s, ack_s, clr_s, ovl_s, bit_en_s, ext_ok_s, bit_word_s} = pins_s;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic        ctrl_legal_sel_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] hrdata_q;
	logic        hreadyout_q;
	logic        hresp_q;
	logic        addr_phase;
	logic [31:0] rd_mux;
	rtcl_pkg::rtcl_state_e state_q, state_d;

	// decode of the address phase and read selection
	assign addr_phase = hsel && htrans[1] && hready;
	assign rd_mux =
		(haddr[7:0] == rtcl_pkg::ADDR_CTRL)   ? {31'h0000_0000, ctrl_legal_sel_q} :
		(haddr[7:0] == rtcl_pkg::ADDR_STATUS) ? {28'h000_0000, (state_q != rtcl_pkg::ST_IDLE),
		                                         tx_shutdown, interrupt_request_out, backend_access_failure} :
		(haddr[7:0] == rtcl_pkg::ADDR_CMD)    ? {20'h0_0000, active_command_bus} :
		(haddr[7:0] == rtcl_pkg::ADDR_VECT)   ? {25'h000_0000, interrupt_reason_vector} :
		(haddr[7:0] == rtcl_pkg::ADDR_BITW)   ? {16'h0000, selftest_word} :
		(haddr[7:0] == rtcl_pkg::ADDR_LASTSW) ? {16'h0000, last_status_word} :
		rtcl_pkg::RDATA_ZERO;

	// zero wait states, read data registered at the address phase
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_pend_q        <= 1'b0;
			wr_addr_q        <= 8'h00;
			hrdata_q         <= rtcl_pkg::RDATA_ZERO;
			hreadyout_q      <= 1'b0;
			hresp_q          <= 1'b0;
			ctrl_legal_sel_q <= rtcl_pkg::CTRL_RESET;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
			wr_pend_q   <= addr_phase && hwrite;
			wr_addr_q   <= haddr[7:0];
			if (addr_phase && !hwrite)
				hrdata_q <= rd_mux;
			if (wr_pend_q && wr_addr_q == rtcl_pkg::ADDR_CTRL)
				ctrl_legal_sel_q <= hwdata[rtcl_pkg::CTRL_LEGAL_SEL_BIT];
		end
	end

	// ----------------------------------------
	// legality sequencer
	// ----------------------------------------
	logic int_ok_q, int_ok_d, accept_sel, leg_expired, fsm_bad, decide;
	logic is_mode;

	assign is_mode  = (rx_cmd_word[rtcl_pkg::CMD_SA_MSB:rtcl_pkg::CMD_SA_LSB] == rtcl_pkg::SA_MODE_LO) ||
	                  (rx_cmd_word[rtcl_pkg::CMD_SA_MSB:rtcl_pkg::CMD_SA_LSB] == rtcl_pkg::SA_MODE_HI);
	assign int_ok_d = is_mode ? rtcl_pkg::rtcl_mode_legal(rx_cmd_word[rtcl_pkg::CMD_TX_BIT],
	                  rx_cmd_word[rtcl_pkg::CMD_WC_MSB:rtcl_pkg::CMD_WC_LSB]) : 1'b1;
	assign accept_sel = ctrl_legal_sel_q ? ext_ok_s : int_ok_q;

	// wait for the external answer to settle before judging
	rtcl_timer #(.CW(LEG_CW), .LIMIT(rtcl_pkg::LEGAL_WAIT_CYC)) u_leg_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.start    (rx_cmd_strobe),
		.abort    (fsm_bad),
		.expired  (leg_expired)
	);

	// next state; a new command restarts the check from every legal state
	always_comb
	begin
		state_d = state_q;
		fsm_bad = 1'b0;
		decide  = 1'b0;
		case (state_q)
			rtcl_pkg::ST_IDLE:
				if (rx_cmd_strobe)
					state_d = rtcl_pkg::ST_CHECK;
			rtcl_pkg::ST_CHECK:
				if (rx_cmd_strobe)
					state_d = rtcl_pkg::ST_CHECK;
				else if (leg_expired)
				begin
					decide  = 1'b1;
					state_d = accept_sel ? rtcl_pkg::ST_ACTIVE : rtcl_pkg::ST_IDLE;
				end
			rtcl_pkg::ST_ACTIVE:
				if (rx_cmd_strobe)
					state_d = rtcl_pkg::ST_CHECK;
				else if (msg_end)
					state_d = rtcl_pkg::ST_IDLE;
			default:
			begin
				fsm_bad = 1'b1;
				state_d = rtcl_pkg::ST_IDLE;
			end
		endcase
	end

	// command outputs; the command only changes on a new command word
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q                     <= rtcl_pkg::ST_IDLE;
			int_ok_q                    <= 1'b0;
			active_command_bus          <= 12'h000;
			command_valid_strobe        <= 1'b0;
			internal_command_accept_out <= 1'b0;
			address_map_latch_enable    <= 1'b0;
			command_decision            <= 1'b0;
			command_accepted            <= 1'b0;
		end
		else
		begin
			state_q                     <= state_d;
			command_valid_strobe        <= rx_cmd_strobe;
			internal_command_accept_out <= int_ok_q;
			address_map_latch_enable    <= decide && accept_sel;
			command_decision            <= decide;
			if (rx_cmd_strobe)
			begin
				active_command_bus <= rx_cmd_word;
				int_ok_q           <= int_ok_d;
			end
			if (decide)
				command_accepted <= accept_sel;
		end
	end

	// ----------------------------------------
	// interrupt, errors and test features
	// ----------------------------------------
	logic irq_event, wd_expired, clear_now, illegal_now, illegal_prev_q;
	logic [1:0] clr_cnt_q;
	logic [5:0] tx_cnt_q;
	logic overflow;

	assign irq_event = xfer_done || mode_done;
	assign clear_now = clr_s && (clr_cnt_q == CLR_LAST);
	assign illegal_now = fsm_bad || other_fsm_illegal;
	assign overflow  = overlength_enable && tx_word_strobe && (tx_cnt_q == TX_LIMIT);

	// backend access watchdog; grant with no wait ends the access
	rtcl_timer #(.CW(WD_CW), .LIMIT(rtcl_pkg::BACKEND_LIMIT_CYC)) u_wd_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.start    (backend_req),
		.abort    (!grant_n_s && wait_n_s),
		.expired  (wd_expired)
	);

	// sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			interrupt_request_out      <= 1'b0;
			interrupt_reason_vector    <= 7'h00;
			vector_extend_latch_enable <= 1'b0;
			backend_access_failure     <= 1'b0;
			clr_cnt_q                  <= 2'b00;
			illegal_prev_q             <= 1'b0;
			illegal_state_flag         <= 1'b0;
		end
		else
		begin
			interrupt_request_out      <= irq_event || (interrupt_request_out && !ack_s);
			vector_extend_latch_enable <= irq_event;
			if (irq_event)
				interrupt_reason_vector <= {mode_done || xfer_good,
					active_command_bus[rtcl_pkg::CMD_TX_BIT],
					active_command_bus[rtcl_pkg::CMD_SA_MSB:rtcl_pkg::CMD_SA_LSB]};
			backend_access_failure <= wd_expired || (backend_access_failure && !clear_now);
			clr_cnt_q <= !clr_s ? 2'b00 : (clr_cnt_q == CLR_LAST) ? clr_cnt_q : clr_cnt_q + 2'b01;
			illegal_prev_q     <= illegal_now;
			illegal_state_flag <= illegal_now && !illegal_prev_q;
		end
	end

	// transmit word count and over-length shutdown; the test pin is normally low
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_cnt_q          <= 6'h00;
			overlength_enable <= 1'b0;
			tx_shutdown       <= 1'b0;
			selftest_word     <= 16'h0000;
		end
		else
		begin
			overlength_enable <= overlength_test_param && ovl_s && active_command_bus[rtcl_pkg::CMD_TX_BIT];
			if (rx_cmd_strobe)
				tx_cnt_q <= 6'h00;
			else if (tx_word_strobe && tx_cnt_q != 6'h3f)
				tx_cnt_q <= tx_cnt_q + 6'h01;
			tx_shutdown   <= overflow || (tx_shutdown && !clear_now);
			selftest_word <= (external_selftest_param && bit_en_s) ? bit_word_s :
				(tx_shutdown ? rtcl_pkg::BIT_TIMEOUT_MASK : 16'h0000);
		end
	end

	// last status word, optionally on its own power-up reset
	generate
		if (init_last_status_param)
		begin : g_pur
			always_ff @(posedge core_clk or negedge powerup_status_reset_n)
			begin
				if (!powerup_status_reset_n)
					last_status_word <= rtcl_pkg::LAST_SW_INIT;
				else if (status_word_load)
					last_status_word <= status_word_in;
			end
		end
		else
		begin : g_norm
			always_ff @(posedge core_clk or negedge rstn)
			begin
				if (!rstn)
					last_status_word <= rtcl_pkg::LAST_SW_INIT;
				else if (status_word_load)
					last_status_word <= status_word_in;
			end
		end
	endgenerate

	assign hreadyout = hreadyout_q;
	assign hresp     = hresp_q;
	assign hrdata    = hrdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_irq_ack_clears: assert property (interrupt_request_out && ack_s && !irq_event |=> !interrupt_request_out)
		else $error("interrupt request not cleared by acknowledge");
	a_irq_holds: assert property (interrupt_request_out && !ack_s |=> interrupt_request_out)
		else $error("interrupt request dropped without acknowledge");
	a_irq_pulse_cause: assert property (ack_s && $past(ack_s) && interrupt_request_out |-> $past(irq_event))
		else $error("interrupt request under acknowledge without an event");
	a_vector_fields: assert property (irq_event |=> interrupt_reason_vector ==
		{$past(mode_done || xfer_good), $past(active_command_bus[10]), $past(active_command_bus[9:5])})
		else $error("interrupt vector fields wrong");
	a_strobe_single: assert property (command_valid_strobe |-> $past(rx_cmd_strobe)
		##1 (!command_valid_strobe || $past(rx_cmd_strobe)))
		else $error("command strobe without a command");
	a_cmd_stable: assert property (state_q == rtcl_pkg::ST_ACTIVE && !rx_cmd_strobe |=> $stable(active_command_bus))
		else $error("active command changed during message");
	a_fail_sets: assert property (wd_expired |=> backend_access_failure)
		else $error("failure flag not set on timeout");
	a_clear_hold: assert property ($fell(backend_access_failure) |-> $past(clr_s, 1) && $past(clr_s, 2) && $past(clr_s, 3))
		else $error("failure cleared by a short clear");
	a_internal_src: assert property (command_decision && !$past(ctrl_legal_sel_q) |-> command_accepted == $past(int_ok_q))
		else $error("internal legality not used");
	a_external_src: assert property (command_decision && $past(ctrl_legal_sel_q) |-> command_accepted == $past(ext_ok_s))
		else $error("external accept not used");
	a_illegal_pulse: assert property (illegal_state_flag |=> !illegal_state_flag)
		else $error("illegal state flag longer than one cycle");
	a_overrun_stop: assert property (overflow |=> tx_shutdown ##1 (selftest_word == rtcl_pkg::BIT_TIMEOUT_MASK
		|| (external_selftest_param && $past(bit_en_s))))
		else $error("over-length transmit not shut down");
endmodule

// [test/rtcl_legal_partner.sv]
// model of the outside command legality and mapping logic
`timescale 1ns/1ps
module rtcl_legal_partner #(
	parameter logic [4:0] REJECT_SA = 5'h07
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        slow,
	input  wire logic [11:0] active_command_bus,
	input  wire logic        command_valid_strobe,
	input  wire logic        address_map_latch_enable,
	input  wire logic        vector_extend_latch_enable,
	output logic             external_command_accept,
	output logic      [11:0] map_cmd_q,
	output logic      [11:0] vec_cmd_q
);
	logic [6:0] wait_q;

	// verdict settles 1 or 60 cycles after a new command; until then the line toggles
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_q                  <= 7'h00;
			external_command_accept <= 1'b0;
		end
		else if (command_valid_strobe)
			wait_q <= slow ? 7'h3c : 7'h01;
		else if (wait_q > 7'h01)
		begin
			wait_q                  <= wait_q - 7'h01;
			external_command_accept <= !external_command_accept;
		end
		else if (wait_q == 7'h01)
		begin
			wait_q                  <= 7'h00;
			external_command_accept <= active_command_bus[9:5] != REJECT_SA;
		end
	end

	// capture the command on the device's latch enables
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			map_cmd_q <= 12'h000;
			vec_cmd_q <= 12'h000;
		end
		else
		begin
			if (address_map_latch_enable)
				map_cmd_q <= active_command_bus;
			if (vector_extend_latch_enable)
				vec_cmd_q <= active_command_bus;
		end
	end
endmodule

// [test/rt_command_legality_irq_tb_top.sv]
// self-checking bench of the command legality block
`timescale 1ns/1ps
module rt_command_legality_irq_tb_top;
	logic        core_clk, rstn, powerup_status_reset_n, hsel, hwrite, rx_cmd_strobe, msg_end, xfer_done;
	logic        xfer_good, mode_done, backend_req, tx_word_strobe, status_word_load, other_fsm_illegal, slow;
	logic        interrupt_acknowledge, backend_grant_n, backend_wait_n, error_clear_input;
	logic        overlength_transmit_test, external_selftest_word_enable, external_command_accept;
	logic        hreadyout, hresp, interrupt_request_out, backend_access_failure, illegal_state_flag;
	logic        command_valid_strobe, internal_command_accept_out, address_map_latch_enable;
	logic        vector_extend_latch_enable, command_decision, command_accepted, overlength_enable, tx_shutdown;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  interrupt_reason_vector;
	logic [11:0] rx_cmd_word, active_command_bus, map_cmd_q, vec_cmd_q;
	logic [15:0] status_word_in, external_selftest_word, selftest_word, last_status_word;
	logic [31:0] haddr, hwdata, hrdata, rd;
	wire         hready = hreadyout;
	int          err_total, checked, k;
	localparam logic [12:0] CMDS [8] = '{13'h1402, 13'h0002, 13'h07e9, 13'h13f1, 13'h1413, 13'h18a4, 13'h1408,
		13'h03f0};

	rtcl_core #(.overlength_test_param(1'b1), .init_last_status_param(1'b1), .external_selftest_param(1'b1)) DUT (
		.core_clk, .rstn, .powerup_status_reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .rx_cmd_strobe, .rx_cmd_word, .msg_end, .xfer_done, .xfer_good, .mode_done,
		.backend_req, .tx_word_strobe, .status_word_load, .status_word_in, .other_fsm_illegal,
		.interrupt_acknowledge, .backend_grant_n, .backend_wait_n, .error_clear_input, .overlength_transmit_test,
		.external_selftest_word_enable, .external_selftest_word, .external_command_accept, .interrupt_request_out,
		.interrupt_reason_vector, .backend_access_failure, .illegal_state_flag, .active_command_bus,
		.command_valid_strobe, .internal_command_accept_out, .address_map_latch_enable, .vector_extend_latch_enable,
		.command_decision, .command_accepted, .overlength_enable, .tx_shutdown, .selftest_word, .last_status_word);

	rtcl_legal_partner partner (.core_clk, .rstn, .slow, .active_command_bus, .command_valid_strobe,
		.address_map_latch_enable, .vector_extend_latch_enable, .external_command_accept, .map_cmd_q, .vec_cmd_q);

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic end_sim();
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a wait that ran out ends the run
	task automatic wt_ok(input logic v);
		if (v !== 1'b1)
		begin
			$display("ERROR t=%0t wait ran out", $time);
			err_total++;
			end_sim();
		end
	endtask

	task automatic hwait();
		int i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (hready !== 1'b1 && i < 50);
		wt_ok(hready);
	endtask

	// one single word transfer, read data left in rd
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hwait();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		hwait();
		rd = hrdata;
	endtask

	// mode 0 internal verdict, 1 prompt partner, 2 slow partner
	task automatic send_cmd(input logic [11:0] w, input logic exp, input logic [1:0] mode);
		@(posedge core_clk);
		rx_cmd_word   <= w;
		rx_cmd_strobe <= 1'b1;
		slow          <= mode[1];
		@(posedge core_clk);
		rx_cmd_strobe <= 1'b0;
		@(negedge core_clk);
		chk(active_command_bus, w);
		chk(command_valid_strobe, 1'b1);
		@(negedge core_clk);
		chk(command_valid_strobe, 1'b0);
		for (int i = 0; i < 200 && command_decision !== 1'b1; i++)
			@(negedge core_clk);
		wt_ok(command_decision);
		chk(active_command_bus, w);
		chk(command_accepted, exp);
		chk(address_map_latch_enable, exp);
		if (mode == 2'd0)
			chk(internal_command_accept_out, exp);
		@(negedge core_clk);
		if (exp)
			chk(map_cmd_q, w);
	endtask

	// transfer event, acknowledge, then an event under a held acknowledge
	task automatic fire(input logic good, input logic [11:0] w);
		@(posedge core_clk);
		xfer_done <= 1'b1;
		xfer_good <= good;
		@(posedge core_clk);
		xfer_done <= 1'b0;
		@(negedge core_clk);
		chk(interrupt_reason_vector, {good, w[10], w[9:5]});
		chk(vector_extend_latch_enable, 1'b1);
		repeat (6) @(negedge core_clk);
		chk(interrupt_request_out, 1'b1);
		chk(vec_cmd_q, w);
		@(posedge core_clk);
		interrupt_acknowledge <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk(interrupt_request_out, 1'b0);
		@(posedge core_clk);
		mode_done <= 1'b1;
		@(posedge core_clk);
		mode_done <= 1'b0;
		@(negedge core_clk);
		chk(interrupt_request_out, 1'b1);
		@(negedge core_clk);
		chk(interrupt_request_out, 1'b0);
		@(posedge core_clk);
		interrupt_acknowledge <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	// main sequence
	initial
	begin
		{core_clk, rstn, hsel, hwrite, rx_cmd_strobe, msg_end, xfer_done, xfer_good, mode_done, backend_req} = '0;
		{tx_word_strobe, status_word_load, other_fsm_illegal, interrupt_acknowledge, error_clear_input, slow} = '0;
		{overlength_transmit_test, external_selftest_word_enable, htrans, haddr, hwdata, rx_cmd_word} = '0;
		{status_word_in, external_selftest_word, err_total, checked, powerup_status_reset_n} = '0;
		{backend_grant_n, backend_wait_n} = 2'b11;
		hsize = 3'b010;
		repeat (5) @(posedge core_clk);
		{rstn, powerup_status_reset_n} <= 2'b11;
		repeat (2) @(negedge core_clk);
		chk(hreadyout, 1'b1);
		chk(interrupt_request_out, 1'b0);
		ahb(1'b0, rtcl_pkg::ADDR_CTRL, 32'h0000_0000);
		chk(rd, rtcl_pkg::RDATA_ZERO);
		ahb(1'b0, 8'h40, 32'h0000_0000);
		chk(rd, rtcl_pkg::RDATA_ZERO);
		chk(hresp, 1'b0);
		$display("register test done");
		foreach (CMDS[j])
			send_cmd(CMDS[j][11:0], CMDS[j][12], 2'd0);
		$display("internal legality test done");
		send_cmd(12'h4a4, 1'b1, 2'd0);
		fire(1'b1, 12'h4a4);
		send_cmd(12'h0a4, 1'b1, 2'd0);
		fire(1'b0, 12'h0a4);
		$display("interrupt test done");
		ahb(1'b1, rtcl_pkg::ADDR_CTRL, 32'h0000_0001);
		ahb(1'b0, rtcl_pkg::ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		send_cmd(12'h409, 1'b1, 2'd2);
		send_cmd(12'h0e4, 1'b0, 2'd1);
		$display("external legality test done");
		@(posedge core_clk);
		overlength_transmit_test <= 1'b1;
		send_cmd(12'h4a4, 1'b1, 2'd1);
		for (k = 0; k < 33; k++)
		begin
			@(posedge core_clk);
			tx_word_strobe <= 1'b1;
			@(posedge core_clk);
			tx_word_strobe <= 1'b0;
			@(negedge core_clk);
			chk(tx_shutdown, k == 32);
		end
		repeat (2) @(negedge core_clk);
		chk(overlength_enable, 1'b1);
		chk(selftest_word & rtcl_pkg::BIT_TIMEOUT_MASK, rtcl_pkg::BIT_TIMEOUT_MASK);
		@(posedge core_clk);
		external_selftest_word_enable <= 1'b1;
		external_selftest_word        <= 16'ha5c3;
		repeat (5) @(negedge core_clk);
		chk(selftest_word, 16'ha5c3);
		$display("over-length test done");
		@(posedge core_clk);
		backend_req <= 1'b1;
		@(posedge core_clk);
		backend_req <= 1'b0;
		for (k = 0; k < 300 && backend_access_failure !== 1'b1; k++)
			@(negedge core_clk);
		wt_ok(backend_access_failure);
		chk(k > 240, 1'b1);
		ahb(1'b0, rtcl_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd[0], 1'b1);
		for (k = 2; k < 5; k += 2)
		begin
			@(posedge core_clk);
			error_clear_input <= 1'b1;
			repeat (k) @(posedge core_clk);
			error_clear_input <= 1'b0;
			repeat (6) @(negedge core_clk);
			chk(backend_access_failure, k == 2);
			chk(tx_shutdown, k == 2);
		end
		$display("backend failure test done");
		@(posedge core_clk);
		other_fsm_illegal <= 1'b1;
		@(posedge core_clk);
		other_fsm_illegal <= 1'b0;
		for (k = 0; k < 10 && illegal_state_flag !== 1'b1; k++)
			@(negedge core_clk);
		wt_ok(illegal_state_flag);
		@(negedge core_clk);
		chk(illegal_state_flag, 1'b0);
		@(posedge core_clk);
		status_word_load <= 1'b1;
		status_word_in   <= 16'h1234;
		@(posedge core_clk);
		status_word_load <= 1'b0;
		@(negedge core_clk);
		chk(last_status_word, 16'h1234);
		@(posedge core_clk);
		powerup_status_reset_n <= 1'b0;
		@(negedge core_clk);
		chk(last_status_word, rtcl_pkg::LAST_SW_INIT);
		$display("flag and status test done");
		end_sim();
	end
endmodule
